/* inc/fhc_params.svh */
`ifndef FHC_PARAMS_SVH
`define FHC_PARAMS_SVH
// ==========
// timing
`define FH_CLK_NS 10
`define FH_SETUP_NS 20
`define FH_STROBE_NS 50
`define FH_HOLD_NS 20
`define FH_SETUP_CYC ((`FH_SETUP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_STROBE_CYC ((`FH_STROBE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_HOLD_CYC ((`FH_HOLD_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_POLL_LIMIT 100000
// ==========
// array
`define FH_AW 17
`define FH_DW 8
`define FH_NSECT 8
`define FH_SECT_SHIFT 14
`define FH_POLL_BIT 7
`define FH_TOG_BIT 6
// ==========
// register offsets
`define FH_O_CMD 8'h00
`define FH_O_ADDR 8'h04
`define FH_O_WDATA 8'h08
`define FH_O_SECT 8'h0C
`define FH_O_STAT 8'h10
`define FH_O_RDATA 8'h14
`define FH_O_INT 8'h18
`define FH_O_MASK 8'h1C
// ==========
// operation codes in the command register
`define FH_OP_READ 4'h0
`define FH_OP_PROG 4'h1
`define FH_OP_CHIP 4'h2
`define FH_OP_SECT 4'h3
`define FH_OP_SUSP 4'h4
`define FH_OP_RES 4'h5
`define FH_OP_FON 4'h6
`define FH_OP_FOFF 4'h7
`define FH_OP_RST 4'h8
// ==========
// interrupt bits
`define FH_I_DONE 0
`define FH_I_REF 1
`define FH_I_TMO 2
`define FH_IW 3
// ==========
// device command words, set per part
`define FH_U1A 17'h00001
`define FH_U1D 8'h01
`define FH_U2A 17'h00002
`define FH_U2D 8'h02
`define FH_C_PROG 8'h10
`define FH_C_ESET 8'h20
`define FH_C_CHIP 8'h30
`define FH_C_SECT 8'h40
`define FH_C_SUSP 8'h50
`define FH_C_RES 8'h60
`define FH_C_FON 8'h70
`define FH_C_FOFF1 8'h80
`define FH_C_FOFF2 8'h00
`define FH_C_RST 8'hF0
`endif

/* inc/fhc_pkg.sv */
package fhc_pkg;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD}
    fhc_cyc_type;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEQ, ST_WAIT_W, ST_POLL, ST_WAIT_P, ST_RD, ST_WAIT_R
  } fhc_state_type;
endpackage

/* core/fhc_bus_cycle.sv */
`timescale 1ns/100ps
`include "fhc_params.svh"
module fhc_bus_cycle
  import fhc_pkg::*;
#(
  parameter int SETUP_CYC = `FH_SETUP_CYC,
  parameter int STROBE_CYC = `FH_STROBE_CYC,
  parameter int HOLD_CYC = `FH_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic wr,
  input wire logic [`FH_AW-1:0] addr_in,
  input wire logic [`FH_DW-1:0] data_in,
  output logic done,
  output logic [`FH_DW-1:0] rdata,
  output logic [`FH_AW-1:0] flash_addr,
  output logic flash_ce_b,
  output logic flash_we_b,
  output logic flash_oe_b,
  input wire logic [`FH_DW-1:0] byte_data_lines_in,
  output logic [`FH_DW-1:0] byte_data_lines_out,
  output logic byte_data_lines_oe
);
  fhc_cyc_type cy_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic ce_b_reg, we_b_reg, oe_b_reg;
  logic [`FH_AW-1:0] addr_reg;
  logic [`FH_DW-1:0] dout_reg, rdata_reg;

  assign done = (cy_reg == CY_HOLD) && (cnt_reg == 8'h00);
  assign rdata = rdata_reg;
  assign flash_addr = addr_reg;
  assign flash_ce_b = ce_b_reg;
  assign flash_we_b = we_b_reg;
  assign flash_oe_b = oe_b_reg;
  assign byte_data_lines_out = dout_reg;
  assign byte_data_lines_oe = wr_reg && (cy_reg != CY_IDLE);

  // ==========
  // one bus cycle: setup, strobe, hold
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cy_reg <= CY_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      ce_b_reg <= 1'b1;
      we_b_reg <= 1'b1;
      oe_b_reg <= 1'b1;
      addr_reg <= '0;
      dout_reg <= '0;
    end else begin
      unique case (cy_reg)
        CY_IDLE: if (start) begin
          cy_reg <= CY_SETUP;
          cnt_reg <= 8'(SETUP_CYC - 1);
          wr_reg <= wr;
          ce_b_reg <= 1'b0;
          addr_reg <= addr_in;
          dout_reg <= data_in;
        end
        CY_SETUP: if (cnt_reg == 8'h00) begin
          // separate strobes keep the data bus free of fights
          cy_reg <= CY_STROBE;
          cnt_reg <= 8'(STROBE_CYC - 1);
          we_b_reg <= !wr_reg;
          oe_b_reg <= wr_reg;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        CY_STROBE: if (cnt_reg == 8'h00) begin
          cy_reg <= CY_HOLD;
          cnt_reg <= 8'(HOLD_CYC - 1);
          we_b_reg <= 1'b1;
          oe_b_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        CY_HOLD: if (cnt_reg == 8'h00) begin
          // chip deselected between cycles puts it in standby
          cy_reg <= CY_IDLE;
          ce_b_reg <= 1'b1;
          wr_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      endcase
    end
  end

  // ==========
  // read data taken at the end of the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (cy_reg == CY_STROBE && cnt_reg == 8'h00 && !wr_reg) begin
      rdata_reg <= byte_data_lines_in;
    end
  end

  // ==========
  // checks
  property p_no_contention;
    @(posedge core_clk) disable iff (!rst_b)
      !flash_oe_b |-> !byte_data_lines_oe && flash_we_b && !flash_ce_b;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("output enable while host drives data");

  property p_write_strobe;
    @(posedge core_clk) disable iff (!rst_b)
      $fell(flash_we_b) |-> byte_data_lines_oe && !flash_ce_b
        ##1 (!flash_we_b || $rose(flash_we_b)) && byte_data_lines_oe;
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe without chip select or data");

  property p_idle_deselect;
    @(posedge core_clk) disable iff (!rst_b)
      (cy_reg == CY_IDLE && !start) [*2] |-> flash_ce_b && flash_oe_b;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("chip left selected while idle");
endmodule

/* core/fhc_flash_host.sv */
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "fhc_params.svh"
// How it works
// - software ops other than read become plain bus write cycles to the flash command port; read is one bus read cycle
// - fast mode programs with two writes, normal mode with four
// - host polls toggle and completion bits until the operation ends or POLL_LIMIT reads have passed
// - host puts the flash in standby by deselecting it
// - chip select, write and output strobes are separate, active low
module fhc_flash_host
  import fhc_pkg::*;
#(
  parameter int POLL_LIMIT = `FH_POLL_LIMIT,
  parameter int NSECT = `FH_NSECT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [`FH_AW-1:0] flash_addr,
  output logic flash_ce_b,
  output logic flash_we_b,
  output logic flash_oe_b,
  input wire logic [`FH_DW-1:0] byte_data_lines_in,
  output logic [`FH_DW-1:0] byte_data_lines_out,
  output logic byte_data_lines_oe
);
  localparam int CW = $clog2(POLL_LIMIT + 1);
  fhc_state_type st_reg;
  logic [3:0] op_reg;
  logic [2:0] step_reg;
  logic [NSECT-1:0] pend_reg, sect_reg;
  logic [`FH_AW-1:0] addr_reg, poll_addr_reg, erase_addr_reg;
  logic [`FH_DW-1:0] wdata_reg, prev_reg, rdata_reg;
  logic first_reg, exp_reg, susp_reg, fast_reg, erasing_reg, sreq_reg;
  logic [CW-1:0] pcnt_reg;
  logic done_ev_reg, tmo_ev_reg;
  logic [`FH_IW-1:0] int_reg, mask_reg;
  logic [31:0] prdata_reg;
  logic [2:0] wcnt_reg;
  logic [1:0] preads_reg;

  logic wr_en, cmd_wr, legal, take, stake, refuse, mapped;
  logic [3:0] op_in;
  logic eng_start, eng_wr, eng_done;
  logic [`FH_AW-1:0] eng_addr, sect_addr;
  logic [`FH_DW-1:0] eng_rdata;
  logic [25:0] word;
  logic seq_last, tog_same, poll_ok;
  logic [2:0] sidx;

  // ==========
  // command words for each op and step
  function automatic logic [25:0] seq_word(input logic [3:0] op,
      input logic [2:0] step, input logic fast,
      input logic [`FH_AW-1:0] ta, input logic [`FH_DW-1:0] td,
      input logic [`FH_AW-1:0] sa);
    logic [`FH_AW-1:0] a;
    logic [`FH_DW-1:0] d;
    logic last;
    a = (step == 3'd1 || step == 3'd4) ? `FH_U2A : `FH_U1A;
    d = (step == 3'd1 || step == 3'd4) ? `FH_U2D : `FH_U1D;
    last = 1'b0;
    unique case (op)
      `FH_OP_PROG: begin
        if (fast ? step == 3'd0 : step == 3'd2) begin
          d = `FH_C_PROG;
        end
        if (fast ? step == 3'd1 : step == 3'd3) begin
          a = ta;
          d = td;
          last = 1'b1;
        end
      end
      `FH_OP_CHIP, `FH_OP_SECT: begin
        if (step == 3'd2) begin
          d = `FH_C_ESET;
        end
        if (step == 3'd5) begin
          a = (op == `FH_OP_CHIP) ? `FH_U1A : sa;
          d = (op == `FH_OP_CHIP) ? `FH_C_CHIP : `FH_C_SECT;
          last = 1'b1;
        end
      end
      `FH_OP_FON: begin
        if (step == 3'd2) begin
          d = `FH_C_FON;
          last = 1'b1;
        end
      end
      `FH_OP_FOFF: begin
        d = (step == 3'd0) ? `FH_C_FOFF1 : `FH_C_FOFF2;
        last = (step == 3'd1);
      end
      `FH_OP_SUSP: begin
        d = `FH_C_SUSP;
        last = 1'b1;
      end
      `FH_OP_RES: begin
        d = `FH_C_RES;
        last = 1'b1;
      end
      default: begin
        d = `FH_C_RST;
        last = 1'b1;
      end
    endcase
    return {last, a, d};
  endfunction

  // lowest selected sector still to be issued
  always_comb begin
    sidx = 3'd0;
    for (int i = NSECT - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        sidx = 3'(i);
      end
    end
  end
  // sectors are 16K apart
  assign sect_addr = `FH_AW'(sidx) << `FH_SECT_SHIFT;
  assign word = seq_word(op_reg, step_reg, fast_reg, addr_reg, wdata_reg,
                         sect_addr);
  // one sector command per chosen sector
  assign seq_last = (op_reg == `FH_OP_SECT && step_reg == 3'd5) ?
    ((pend_reg & ~(NSECT'(1) << sidx)) == '0) : word[25];

  // ==========
  // apb slave
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `FH_O_MASK);
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign cmd_wr = wr_en && (paddr == `FH_O_CMD);
  assign op_in = pwdata[3:0];
  assign irq = |(int_reg & mask_reg);

  always_comb begin
    unique case (op_in)
      `FH_OP_READ, `FH_OP_PROG, `FH_OP_FON, `FH_OP_FOFF, `FH_OP_RST:
        legal = 1'b1;
      // no new erase while one is on hold
      `FH_OP_CHIP: legal = !susp_reg;
      `FH_OP_SECT: legal = !susp_reg && (sect_reg != '0);
      `FH_OP_RES: legal = susp_reg;
      default: legal = 1'b0;
    endcase
  end
  assign take = cmd_wr && (st_reg == ST_IDLE) && legal;
  // suspend only cuts into erase polling
  assign stake = cmd_wr && (op_in == `FH_OP_SUSP) && erasing_reg &&
    !sreq_reg && (st_reg == ST_POLL || st_reg == ST_WAIT_P);
  // reads while busy are refused, the array shows status
  assign refuse = cmd_wr && !take && !stake;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      sect_reg <= '0;
      mask_reg <= '0;
    end else if (wr_en) begin
      if (paddr == `FH_O_ADDR) addr_reg <= pwdata[`FH_AW-1:0];
      if (paddr == `FH_O_WDATA) wdata_reg <= pwdata[`FH_DW-1:0];
      if (paddr == `FH_O_SECT) sect_reg <= pwdata[NSECT-1:0];
      if (paddr == `FH_O_MASK) mask_reg <= pwdata[`FH_IW-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable) begin
      unique case (paddr)
        `FH_O_ADDR: prdata_reg <= 32'(addr_reg);
        `FH_O_WDATA: prdata_reg <= 32'(wdata_reg);
        `FH_O_SECT: prdata_reg <= 32'(sect_reg);
        `FH_O_STAT: prdata_reg <= {28'h0, fast_reg, erasing_reg,
                                   susp_reg, st_reg != ST_IDLE};
        `FH_O_RDATA: prdata_reg <= 32'(rdata_reg);
        `FH_O_INT: prdata_reg <= 32'(int_reg);
        `FH_O_MASK: prdata_reg <= 32'(mask_reg);
        default: prdata_reg <= 32'h0;
      endcase
    end
  end

  // sticky events, set beats a write-one clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      int_reg <= '0;
    end else begin
      int_reg <= (int_reg & ~((wr_en && paddr == `FH_O_INT) ?
                  pwdata[`FH_IW-1:0] : '0))
               | {tmo_ev_reg, refuse, done_ev_reg};
    end
  end

  // ==========
  // sequencer
  assign eng_start = (st_reg == ST_SEQ) || (st_reg == ST_POLL) ||
                     (st_reg == ST_RD);
  assign eng_wr = (st_reg == ST_SEQ);
  assign eng_addr = (st_reg == ST_SEQ) ? word[24:8] :
                    (st_reg == ST_POLL) ? poll_addr_reg : addr_reg;
  // flash runs its own algorithm, host watches the toggle and data poll bits
  assign tog_same = eng_rdata[`FH_TOG_BIT] == prev_reg[`FH_TOG_BIT];
  assign poll_ok = tog_same && (eng_rdata[`FH_POLL_BIT] == exp_reg);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;
      op_reg <= `FH_OP_RST;
      step_reg <= 3'd0;
      pend_reg <= '0;
      poll_addr_reg <= '0;
      erase_addr_reg <= '0;
      prev_reg <= '0;
      rdata_reg <= '0;
      first_reg <= 1'b0;
      exp_reg <= 1'b0;
      susp_reg <= 1'b0;
      fast_reg <= 1'b0;
      erasing_reg <= 1'b0;
      sreq_reg <= 1'b0;
      pcnt_reg <= '0;
      done_ev_reg <= 1'b0;
      tmo_ev_reg <= 1'b0;
    end else begin
      done_ev_reg <= 1'b0;
      tmo_ev_reg <= 1'b0;
      if (stake) sreq_reg <= 1'b1;
      unique case (st_reg)
        ST_IDLE: if (take) begin
          op_reg <= op_in;
          step_reg <= 3'd0;
          pend_reg <= sect_reg;
          st_reg <= (op_in == `FH_OP_READ) ? ST_RD : ST_SEQ;
        end
        ST_SEQ: st_reg <= ST_WAIT_W;
        ST_WAIT_W: if (eng_done) begin
          if (op_reg == `FH_OP_SECT && step_reg == 3'd5) begin
            pend_reg[sidx] <= 1'b0;
            erase_addr_reg <= sect_addr;
            poll_addr_reg <= sect_addr;
          end
          if (!seq_last) begin
            st_reg <= ST_SEQ;
            if (step_reg != 3'd5) step_reg <= step_reg + 3'd1;
          end else begin
            first_reg <= 1'b1;
            pcnt_reg <= '0;
            st_reg <= ST_POLL;
            unique case (op_reg)
              // program: data bit shows true once written
              `FH_OP_PROG: begin
                poll_addr_reg <= addr_reg;
                exp_reg <= wdata_reg[`FH_POLL_BIT];
              end
              // erase ends with all ones
              `FH_OP_CHIP: begin
                poll_addr_reg <= `FH_U1A;
                erase_addr_reg <= `FH_U1A;
                exp_reg <= 1'b1;
                erasing_reg <= 1'b1;
              end
              `FH_OP_SECT: begin
                exp_reg <= 1'b1;
                erasing_reg <= 1'b1;
              end
              `FH_OP_RES: begin
                poll_addr_reg <= erase_addr_reg;
                exp_reg <= 1'b1;
                erasing_reg <= 1'b1;
                susp_reg <= 1'b0;
              end
              default: begin
                st_reg <= ST_IDLE;
                done_ev_reg <= 1'b1;
                if (op_reg == `FH_OP_FON) fast_reg <= 1'b1;
                if (op_reg == `FH_OP_FOFF) fast_reg <= 1'b0;
                if (op_reg == `FH_OP_SUSP) begin
                  susp_reg <= 1'b1;
                  erasing_reg <= 1'b0;
                end
              end
            endcase
          end
        end
        ST_POLL: st_reg <= ST_WAIT_P;
        ST_WAIT_P: if (eng_done) begin
          prev_reg <= eng_rdata;
          first_reg <= 1'b0;
          pcnt_reg <= pcnt_reg + CW'(1);
          if (sreq_reg) begin
            sreq_reg <= 1'b0;
            op_reg <= `FH_OP_SUSP;
            step_reg <= 3'd0;
            st_reg <= ST_SEQ;
          end else if (!first_reg && poll_ok) begin
            // back to array reads, ready for a new command
            rdata_reg <= eng_rdata;
            erasing_reg <= 1'b0;
            done_ev_reg <= 1'b1;
            st_reg <= ST_IDLE;
          end else if (pcnt_reg == CW'(POLL_LIMIT - 1)) begin
            erasing_reg <= 1'b0;
            tmo_ev_reg <= 1'b1;
            st_reg <= ST_IDLE;
          end else begin
            st_reg <= ST_POLL;
          end
        end
        ST_RD: st_reg <= ST_WAIT_R;
        ST_WAIT_R: if (eng_done) begin
          rdata_reg <= eng_rdata;
          done_ev_reg <= 1'b1;
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  fhc_bus_cycle u_cyc (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(eng_start),
    .wr(eng_wr),
    .addr_in(eng_addr),
    .data_in(word[7:0]),
    .done(eng_done),
    .rdata(eng_rdata),
    .flash_addr(flash_addr),
    .flash_ce_b(flash_ce_b),
    .flash_we_b(flash_we_b),
    .flash_oe_b(flash_oe_b),
    .byte_data_lines_in(byte_data_lines_in),
    .byte_data_lines_out(byte_data_lines_out),
    .byte_data_lines_oe(byte_data_lines_oe)
  );

  // ==========
  // checker helpers: writes per op and reads per poll
  always_ff @(posedge core_clk) begin
    if (!rst_b || take) begin
      wcnt_reg <= 3'd0;
    end else if (st_reg == ST_SEQ && wcnt_reg != 3'd7) begin
      wcnt_reg <= wcnt_reg + 3'd1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b || st_reg == ST_WAIT_W) begin
      preads_reg <= 2'd0;
    end else if (st_reg == ST_WAIT_P && eng_done && preads_reg != 2'd3) begin
      preads_reg <= preads_reg + 2'd1;
    end
  end

  sequence s_prog_end;
    st_reg == ST_WAIT_W && eng_done && seq_last && op_reg == `FH_OP_PROG;
  endsequence
  property p_prog_writes;
    @(posedge core_clk) disable iff (!rst_b)
      s_prog_end |-> wcnt_reg == (fast_reg ? 3'd2 : 3'd4);
  endproperty
  a_prog_writes: assert property (p_prog_writes)
    else $error("wrong number of program writes");

  sequence s_cmd_issue;
    ##1 eng_start ##1 !eng_start;
  endsequence
  property p_cmd_starts;
    @(posedge core_clk) disable iff (!rst_b)
      take |-> s_cmd_issue;
  endproperty
  a_cmd_starts: assert property (p_cmd_starts)
    else $error("accepted command did not start a bus cycle");

  property p_poll_two_reads;
    @(posedge core_clk) disable iff (!rst_b)
      (st_reg == ST_WAIT_P && eng_done && !sreq_reg && !first_reg &&
       poll_ok) |=> done_ev_reg && st_reg == ST_IDLE && preads_reg >= 2'd2;
  endproperty
  a_poll_two_reads: assert property (p_poll_two_reads)
    else $error("poll ended without two matching reads");

  property p_susp_refuse;
    @(posedge core_clk) disable iff (!rst_b)
      (cmd_wr && susp_reg && op_in == `FH_OP_CHIP) |=>
        int_reg[`FH_I_REF] && (op_reg != `FH_OP_CHIP);
  endproperty
  a_susp_refuse: assert property (p_susp_refuse)
    else $error("erase accepted while suspended");

  property p_irq_level;
    @(posedge core_clk) disable iff (!rst_b)
      (refuse && mask_reg[`FH_I_REF]) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("masked-in event did not raise irq");
endmodule

/* test/fhc_flash_model.sv */
`timescale 1ns/100ps
`include "fhc_params.svh"
// ==========
// behavioural flash part on the far side of the host
module fhc_flash_model #(
  parameter logic [7:0] PROT = 8'h80,
  parameter int BUSY_READS = 3
) (
  input wire logic [`FH_AW-1:0] flash_addr,
  input wire logic flash_ce_b,
  input wire logic flash_we_b,
  input wire logic flash_oe_b,
  input wire logic [`FH_DW-1:0] dq_from_host,
  output logic [`FH_DW-1:0] dq_to_host
);
  logic [7:0] mem [0:131071];
  logic [7:0] last_q = 8'h00;
  logic [7:0] expect_q = 8'h00;
  logic tog = 1'b0;
  logic fast = 1'b0;
  logic unl = 1'b0;
  logic prog_next = 1'b0;
  // supply monitor, held good here; low blocks every write
  logic supply_ok = 1'b1;
  logic [2:0] sec;
  int busy = 0;
  // shipped fully erased
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
  end
  // ==========
  // commands latch on the trailing write strobe edge
  always @(posedge flash_we_b) begin
    if (!flash_ce_b && supply_ok) begin
      sec = flash_addr[16:14];
      if (prog_next) begin
        if (!PROT[sec]) mem[flash_addr] = mem[flash_addr] & dq_from_host;
        expect_q = dq_from_host;
        busy = BUSY_READS;
        prog_next = 1'b0;
      end else if (dq_from_host == `FH_C_PROG) begin
        prog_next = fast || unl;
      end else if (dq_from_host == `FH_C_FON && unl) begin
        fast = 1'b1;
      end else if (dq_from_host == `FH_C_FOFF2 && fast) begin
        fast = 1'b0;
      end else if (dq_from_host == `FH_C_CHIP && unl) begin
        for (int i = 0; i < 131072; i++) if (!PROT[i>>14]) mem[i] = 8'hFF;
        expect_q = 8'hFF;
        busy = BUSY_READS;
      end else if (dq_from_host == `FH_C_SECT) begin
        for (int i = 0; i < 16384; i++)
          if (!PROT[sec]) mem[{sec, i[13:0]}] = 8'hFF;
        expect_q = 8'hFF;
        busy = BUSY_READS;
      end
      unl = flash_addr == `FH_U2A && dq_from_host == `FH_U2D;
    end
  end
  // ==========
  // reads show status while busy, array data after
  always @(negedge flash_oe_b) begin
    if (!flash_ce_b && busy > 0) begin
      tog = ~tog;
      last_q = {~expect_q[7], tog, 6'h00};
      busy--;
    end else if (!flash_ce_b) begin
      last_q = mem[flash_addr];
    end
  end
  // released bus shows the inverse so a stale byte never looks valid
  assign dq_to_host = (!flash_ce_b && !flash_oe_b) ? last_q : ~last_q;
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
`include "fhc_params.svh"
module tb_top;
  import fhc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, ce_b, we_b, oe_b, dq_oe, err;
  logic [16:0] faddr;
  logic [7:0] dq_out, dq_dev, dq_wire;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_wr = 0;
  logic [2:0] mask_v = 3'h0;
  assign dq_wire = dq_oe ? dq_out : dq_dev;
  fhc_flash_host #(.POLL_LIMIT(50), .NSECT(8)) fhc_flash_host_inst (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .flash_addr(faddr),
    .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b),
    .byte_data_lines_in(dq_wire), .byte_data_lines_out(dq_out),
    .byte_data_lines_oe(dq_oe));
  fhc_flash_model fhc_flash_model_inst (.flash_addr(faddr),
    .flash_ce_b(ce_b), .flash_we_b(we_b), .flash_oe_b(oe_b),
    .dq_from_host(dq_wire), .dq_to_host(dq_dev));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge we_b) n_wr++;
  // ==========
  // shared tasks
  task give_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_stat(input logic [3:0] v);
    int k;
    k = 0;
    do begin apb(1'b0, `FH_O_STAT, 32'h0); k++; end
    while (rd[3:0] !== v && k < 500);
    chk("status", {28'h0, v}, rd);
  endtask
  // stale events cleared first, else the wait ends on an old bit
  task op(input logic [3:0] code, input int ib);
    int k;
    k = 0;
    apb(1'b1, `FH_O_INT, 32'h7);
    n_wr = 0;
    apb(1'b1, `FH_O_CMD, {28'h0, code});
    do begin apb(1'b0, `FH_O_INT, 32'h0); k++; end
    while (rd[ib] !== 1'b1 && k < 3000);
    chk("int bit", 32'h1, {31'h0, rd[ib]});
    chk("irq set", {31'h0, mask_v[ib]}, {31'h0, irq});
    apb(1'b1, `FH_O_INT, 32'h7);
    // the clear lands at the access edge, look one edge later
    @(posedge core_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    chk("idle select", 32'h1, {31'h0, ce_b});
  endtask
  task rd_array(input logic [16:0] a, input logic [7:0] e);
    apb(1'b1, `FH_O_ADDR, {15'h0, a});
    op(`FH_OP_READ, `FH_I_DONE);
    apb(1'b0, `FH_O_RDATA, 32'h0);
    chk("array byte", {24'h0, e}, rd);
  endtask
  task prog(input logic [16:0] a, input logic [7:0] d);
    apb(1'b1, `FH_O_ADDR, {15'h0, a});
    apb(1'b1, `FH_O_WDATA, {24'h0, d});
    op(`FH_OP_PROG, `FH_I_DONE);
  endtask
  // ==========
  // scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, `FH_O_STAT, 32'h0);
    chk("reset status", 32'h0, rd);
    chk("reset irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    mask_v = 3'h1;
    apb(1'b1, `FH_O_MASK, {29'h0, mask_v});
    prog(17'h04123, 8'h5A);
    chk("normal writes", 32'd4, n_wr);
    rd_array(17'h04123, 8'h5A);
    apb(1'b1, `FH_O_CMD, {28'h0, `FH_OP_FON});
    wait_stat(4'h8);
    prog(17'h08200, 8'h3C);
    chk("fast writes", 32'd2, n_wr);
    apb(1'b1, `FH_O_CMD, {28'h0, `FH_OP_FOFF});
    wait_stat(4'h0);
    apb(1'b1, `FH_O_SECT, 32'h2);
    op(`FH_OP_SECT, `FH_I_DONE);
    rd_array(17'h04123, 8'hFF);
    rd_array(17'h08200, 8'h3C);
    op(`FH_OP_CHIP, `FH_I_DONE);
    rd_array(17'h08200, 8'hFF);
    prog(17'h1C000, 8'h85);
    rd_array(17'h1C000, 8'hFF);
    apb(1'b1, `FH_O_SECT, 32'h4);
    apb(1'b1, `FH_O_CMD, {28'h0, `FH_OP_SECT});
    wait_stat(4'h5);
    apb(1'b1, `FH_O_CMD, {28'h0, `FH_OP_SUSP});
    wait_stat(4'h2);
    op(`FH_OP_CHIP, `FH_I_REF);
    prog(17'h00010, 8'h11);
    op(`FH_OP_RES, `FH_I_DONE);
    rd_array(17'h00010, 8'h11);
    rd_array(17'h08200, 8'hFF);
    op(`FH_OP_RST, `FH_I_DONE);
    mask_v = 3'h3;
    apb(1'b1, `FH_O_MASK, {29'h0, mask_v});
    op(4'h9, `FH_I_REF);
    give_verdict();
  end
endmodule
